// file: bench/test_zero_crossing_timing_unit.sv
// bench for the zero-crossing timing unit: apb register calls plus detector pulses.
// assumes zero-wait apb and the 50 MHz fractional timebase of the package.
`default_nettype none

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD %0t got %h want %h", $time, (a), (b)); end end

module test_zero_crossing_timing_unit;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // wiring
  // ----------------------------------------------------------------
  localparam logic [15:0] st = zx_timing_pkg::IDX_MAIN_STATUS;
  localparam logic [15:0] mk = zx_timing_pkg::IDX_MAIN_INTERRUPT_MASK;
  localparam logic [15:0] d0 = zx_timing_pkg::IDX_DELAY_RESULT_0;
  localparam logic [15:0] rl = zx_timing_pkg::IDX_CROSSING_TIMEOUT_RELOAD;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, irq_n, rerr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [2:0] vc, vr, cc, cr, vq;
  logic [1:0] ra, rb, rc;
  int bad_count, checks_done, cyc;
  logic [2:0] sv[3] = '{3'h1, 3'h1, 3'h0};
  logic [2:0] sc[3] = '{3'h1, 3'h0, 3'h1};
  logic [2:0] ev[3] = '{3'h0, 3'h4, 3'h0};
  logic [2:0] ec[3] = '{3'h1, 3'h0, 3'h2};
  logic [15:0] dr[3] = '{d0, d0, zx_timing_pkg::IDX_DELAY_RESULT_2};

  zero_crossing_timing_unit zero_crossing_timing_unit_inst (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr), .volt_cross(vc),
    .volt_rise(vr), .curr_cross(cc), .curr_rise(cr), .volt_below_noise(vq),
    .interrupt_line_one_n(irq_n), .voltage_route_phase_a(ra), .voltage_route_phase_b(rb),
    .voltage_route_phase_c(rc));
  zx_source zx_source_inst (.clock(clock), .volt_cross(vc), .volt_rise(vr), .curr_cross(cc),
    .curr_rise(cr), .volt_below_noise(vq));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // apb master and verdict
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // the full run needs about 64000 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    apb(1'b0, rl, 32'h0);
    `CHK(rdat[15:0], zx_timing_pkg::RELOAD_RESET)
    apb(1'b0, 16'h0001, 32'h0);
    `CHK(rerr, 1'b1)
    apb(1'b1, zx_timing_pkg::IDX_GENERAL_CONFIGURATION, 32'h3900);
    // the write lands at the access edge, so look once it has settled
    @(negedge clock);
    `CHK({rc, rb, ra}, 6'h39)
    apb(1'b1, zx_timing_pkg::IDX_GENERAL_CONFIGURATION, 32'h0);
    // 1953 clocks is ten 256 kHz ticks, give or take one
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, zx_timing_pkg::IDX_COMPUTATION_MODE, 32'(m) << 9);
      zx_source_inst.fire(sv[m], sc[m]);
      repeat (1951) @(posedge clock);
      zx_source_inst.fire(ev[m], ec[m]);
      apb(1'b0, dr[m], 32'h0);
      `CHK(rdat[15:0] >= 16'd9 && rdat[15:0] <= 16'd11, 1'b1)
    end
    // the first period after reset is partial, so only a later one is read
    zx_source_inst.fire(3'h1, 3'h0);
    repeat (3904) @(posedge clock);
    zx_source_inst.fire(3'h1, 3'h0);
    apb(1'b0, zx_timing_pkg::IDX_PHASE_A_LINE_PERIOD, 32'h0);
    `CHK(rdat[15:0] >= 16'd19 && rdat[15:0] <= 16'd21, 1'b1)
    // the delay tests sent A then C; leaving three-sensor mode drops that latch
    apb(1'b1, zx_timing_pkg::IDX_ACCUMULATION_MODE, 32'h10);
    apb(1'b1, zx_timing_pkg::IDX_ACCUMULATION_MODE, 32'h0);
    apb(1'b1, st, 32'h0008_0000);
    apb(1'b1, mk, 32'h0008_0000);
    zx_source_inst.fire(3'h1, 3'h0);
    zx_source_inst.fire(3'h4, 3'h0);
    zx_source_inst.fire(3'h2, 3'h0);
    apb(1'b0, st, 32'h0);
    `CHK(rdat[19], 1'b1)
    `CHK(irq_n, 1'b0)
    apb(1'b1, st, 32'h0008_0000);
    apb(1'b0, st, 32'h0);
    `CHK(rdat[19], 1'b0)
    `CHK(irq_n, 1'b1)
    zx_source_inst.fire(3'h1, 3'h0);
    apb(1'b0, st, 32'h0);
    `CHK(rdat[19], 1'b1)
    apb(1'b1, zx_timing_pkg::IDX_ACCUMULATION_MODE, 32'h10);
    apb(1'b1, st, 32'h0008_0000);
    zx_source_inst.fire(3'h1, 3'h0);
    zx_source_inst.fire(3'h4, 3'h0);
    zx_source_inst.fire(3'h2, 3'h0);
    apb(1'b0, st, 32'h0);
    `CHK(rdat[19], 1'b0)
    apb(1'b1, zx_timing_pkg::IDX_ACCUMULATION_MODE, 32'h0);
    // reload 1: expiry comes on slow tick 17 after the crossing, within 53125 clocks
    apb(1'b1, rl, 32'h1);
    apb(1'b1, mk, 32'h40);
    zx_source_inst.fire(3'h0, 3'h1);
    repeat (46870) @(posedge clock);
    apb(1'b0, st, 32'h0);
    `CHK(rdat[6], 1'b0)
    `CHK(irq_n, 1'b1)
    repeat (7200) @(posedge clock);
    apb(1'b0, st, 32'h0);
    `CHK(rdat[6], 1'b1)
    `CHK(irq_n, 1'b0)
    apb(1'b1, st, 32'h40);
    apb(1'b0, st, 32'h0);
    `CHK(rdat[6], 1'b0)
    `CHK(irq_n, 1'b1)
    print_verdict();
  end
endmodule

`default_nettype wire

// file: bench/zx_source.sv
// behavioural zero-crossing detector front end: one-cycle crossing pulses on command.
// assumes the bench calls fire() from one process, on the shared clock.
`default_nettype none

module zx_source (
  input wire logic clock,
  output logic [2:0] volt_cross,
  output logic [2:0] volt_rise,
  output logic [2:0] curr_cross,
  output logic [2:0] curr_rise,
  output logic [2:0] volt_below_noise
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // event pulses
  // ----------------------------------------------------------------
  initial begin
    volt_cross = 3'h0;
    volt_rise = 3'h0;
    curr_cross = 3'h0;
    curr_rise = 3'h0;
    // limitation: every phase stays above the noise floor
    volt_below_noise = 3'h0;
  end

  // a rising crossing is also a crossing, so both strobes pulse together
  task automatic fire(input logic [2:0] vr, input logic [2:0] cr);
    @(posedge clock);
    volt_rise <= vr;
    volt_cross <= vr;
    curr_rise <= cr;
    curr_cross <= cr;
    @(posedge clock);
    volt_rise <= 3'h0;
    volt_cross <= 3'h0;
    curr_rise <= 3'h0;
    curr_cross <= 3'h0;
  endtask
endmodule

`default_nettype wire

// file: src/zero_crossing_timing_unit.sv
// zero-crossing timing unit: timeout counters, phase sequence check, delay and period
// measurement, status/mask with active-low interrupt, APB register slave.
// assumes crossing and rise pulses come from same-clock detector logic, one cycle each.
`default_nettype none

// Functional notes
// - masked timeout flag pulls interrupt low
// - write one clears timeout flag, releases
// - reload counts 62.5 us slow ticks
// - decrement starts 1 ms after crossing
// - quiet voltage ignores crossings, keeps decrementing
// - sequence check uses voltage rising crossings
// - A then C sets sequence error
// - masked sequence error interrupts, write clears
// - after error, every rise sets flag
// - sequence check only with connection 00
// - config fields route voltages to phases
// - delays start/stop on rising crossings
// - selector picks one delay set
// - mode 00 stores voltage-current delays
// - mode 01 stores voltage-voltage delays
// - mode 10 stores current-current delays
// - delays count 256 kHz ticks
// - period stored every line period
// - period counts 256 kHz ticks
// - timeout reload, decrement, zero sets flag
// - timeout flags at status bits 3..8
module zero_crossing_timing_unit (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] volt_cross,
  input wire logic [2:0] volt_rise,
  input wire logic [2:0] curr_cross,
  input wire logic [2:0] curr_rise,
  input wire logic [2:0] volt_below_noise,
  output logic interrupt_line_one_n,
  output logic [1:0] voltage_route_phase_a,
  output logic [1:0] voltage_route_phase_b,
  output logic [1:0] voltage_route_phase_c
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe_r;
  logic rst_sync_n;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) rst_pipe_r <= 2'b00;
    else rst_pipe_r <= {rst_pipe_r[0], 1'b1};
  end
  assign rst_sync_n = rst_pipe_r[1];

  // ----------------------------------------------------------------
  // timebases
  // ----------------------------------------------------------------
  // 50 MHz is not a whole multiple of 256 kHz, so a phase accumulator keeps
  // the average rate exact at the cost of one clock of jitter per tick
  logic [16:0] acc_r;
  logic [16:0] acc_sum;
  logic fast_tick;
  logic [3:0] slow_div_r;
  logic slow_tick;

  assign acc_sum = acc_r + 17'(zx_timing_pkg::FAST_TICK_KHZ);
  assign fast_tick = (acc_sum >= 17'(zx_timing_pkg::CLOCK_KHZ));
  assign slow_tick = fast_tick && (slow_div_r == 4'(zx_timing_pkg::SLOW_DIV - 1));

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      acc_r <= 17'h00000;
      slow_div_r <= 4'h0;
    end else begin
      acc_r <= fast_tick ? acc_sum - 17'(zx_timing_pkg::CLOCK_KHZ) : acc_sum;
      if (fast_tick) slow_div_r <= slow_div_r + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------
  logic [15:0] reg_idx;
  logic [31:0] wmask;
  logic wr_en;
  logic setup;
  logic hit;
  logic wr_status, wr_mask, wr_reload, wr_comp, wr_config, wr_accum;
  logic [31:0] rd_mux;
  logic [31:0] status_r, status_nxt, status_set, status_clr;
  logic [31:0] mask_r;
  logic [15:0] reload_r, comp_r, config_r;
  logic [7:0] accum_r;
  logic [15:0] delay_r [3];
  logic [15:0] period_r [3];
  logic unmapped_r;

  assign reg_idx = paddr[17:2];
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign setup = psel && !penable;
  // a misaligned address reports an error and must not touch any register
  assign wr_en = psel && penable && pwrite && (paddr[1:0] == 2'b00);
  assign wr_status = wr_en && (reg_idx == zx_timing_pkg::IDX_MAIN_STATUS);
  assign wr_mask = wr_en && (reg_idx == zx_timing_pkg::IDX_MAIN_INTERRUPT_MASK);
  assign wr_reload = wr_en && (reg_idx == zx_timing_pkg::IDX_CROSSING_TIMEOUT_RELOAD);
  assign wr_comp = wr_en && (reg_idx == zx_timing_pkg::IDX_COMPUTATION_MODE);
  assign wr_config = wr_en && (reg_idx == zx_timing_pkg::IDX_GENERAL_CONFIGURATION);
  assign wr_accum = wr_en && (reg_idx == zx_timing_pkg::IDX_ACCUMULATION_MODE);

  assign rd_mux =
    (reg_idx == zx_timing_pkg::IDX_MAIN_STATUS) ? status_r :
    (reg_idx == zx_timing_pkg::IDX_MAIN_INTERRUPT_MASK) ? mask_r :
    (reg_idx == zx_timing_pkg::IDX_DELAY_RESULT_0) ? {16'h0000, delay_r[0]} :
    (reg_idx == zx_timing_pkg::IDX_DELAY_RESULT_1) ? {16'h0000, delay_r[1]} :
    (reg_idx == zx_timing_pkg::IDX_DELAY_RESULT_2) ? {16'h0000, delay_r[2]} :
    (reg_idx == zx_timing_pkg::IDX_CROSSING_TIMEOUT_RELOAD) ? {16'h0000, reload_r} :
    (reg_idx == zx_timing_pkg::IDX_COMPUTATION_MODE) ? {16'h0000, comp_r} :
    (reg_idx == zx_timing_pkg::IDX_GENERAL_CONFIGURATION) ? {16'h0000, config_r} :
    (reg_idx == zx_timing_pkg::IDX_ACCUMULATION_MODE) ? {24'h000000, accum_r} :
    (reg_idx == zx_timing_pkg::IDX_PHASE_A_LINE_PERIOD) ? {16'h0000, period_r[0]} :
    (reg_idx == zx_timing_pkg::IDX_PHASE_B_LINE_PERIOD) ? {16'h0000, period_r[1]} :
    (reg_idx == zx_timing_pkg::IDX_PHASE_C_LINE_PERIOD) ? {16'h0000, period_r[2]} :
    32'h0000_0000;

  assign hit = (paddr[1:0] == 2'b00) && (
    (reg_idx == zx_timing_pkg::IDX_MAIN_STATUS) ||
    (reg_idx == zx_timing_pkg::IDX_MAIN_INTERRUPT_MASK) ||
    (reg_idx == zx_timing_pkg::IDX_DELAY_RESULT_0) ||
    (reg_idx == zx_timing_pkg::IDX_DELAY_RESULT_1) ||
    (reg_idx == zx_timing_pkg::IDX_DELAY_RESULT_2) ||
    (reg_idx == zx_timing_pkg::IDX_CROSSING_TIMEOUT_RELOAD) ||
    (reg_idx == zx_timing_pkg::IDX_COMPUTATION_MODE) ||
    (reg_idx == zx_timing_pkg::IDX_GENERAL_CONFIGURATION) ||
    (reg_idx == zx_timing_pkg::IDX_ACCUMULATION_MODE) ||
    (reg_idx == zx_timing_pkg::IDX_PHASE_A_LINE_PERIOD) ||
    (reg_idx == zx_timing_pkg::IDX_PHASE_B_LINE_PERIOD) ||
    (reg_idx == zx_timing_pkg::IDX_PHASE_C_LINE_PERIOD));

  // read data is captured in the setup cycle, so the slave never waits
  assign pready = 1'b1;
  assign pslverr = psel && penable && unmapped_r;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata <= 32'h0000_0000;
      unmapped_r <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      unmapped_r <= !hit;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mask_r <= 32'h0000_0000;
      reload_r <= zx_timing_pkg::RELOAD_RESET;
      comp_r <= zx_timing_pkg::MODE_RESET;
      config_r <= zx_timing_pkg::MODE_RESET;
      accum_r <= zx_timing_pkg::ACCUM_RESET;
    end else begin
      if (wr_mask) mask_r <= pwdata & wmask & zx_timing_pkg::STATUS_FLAG_MASK;
      if (wr_reload) reload_r <= (reload_r & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
      if (wr_comp) comp_r <= (comp_r & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
      if (wr_config) config_r <= (config_r & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
      if (wr_accum && pstrb[0]) accum_r <= pwdata[7:0];
    end
  end

  zx_timing_pkg::delay_set_e delay_sel;
  logic conn_three_sensors;

  assign delay_sel = zx_timing_pkg::delay_set_e'(
    comp_r[zx_timing_pkg::DELAY_SET_SELECT_LO +: 2]);
  assign conn_three_sensors = (accum_r[zx_timing_pkg::CONNECTION_SELECT_LO +: 2] == 2'b00);
  assign voltage_route_phase_a = config_r[zx_timing_pkg::VOLTAGE_ROUTE_A_LO +: 2];
  assign voltage_route_phase_b = config_r[zx_timing_pkg::VOLTAGE_ROUTE_B_LO +: 2];
  assign voltage_route_phase_c = config_r[zx_timing_pkg::VOLTAGE_ROUTE_C_LO +: 2];

  // ----------------------------------------------------------------
  // crossing timeout counters
  // ----------------------------------------------------------------
  // channels 0..2 are voltages A..C, 3..5 currents A..C
  logic [5:0] cross_ok;
  logic [5:0] expire;

  // a quiet voltage channel lets its counter run down through noise crossings
  assign cross_ok = {curr_cross, volt_cross & ~volt_below_noise};

  for (genvar ch = 0; ch < 6; ch++) begin : gen_tout
    logic [15:0] tout_r;
    logic [4:0] hold_r;

    assign expire[ch] = slow_tick && !cross_ok[ch] && (hold_r == 5'd0)
                        && (tout_r == 16'h0001);

    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        tout_r <= zx_timing_pkg::RELOAD_RESET;
        hold_r <= 5'(zx_timing_pkg::HOLD_TICKS);
      end else if (cross_ok[ch]) begin
        tout_r <= reload_r;
        hold_r <= 5'(zx_timing_pkg::HOLD_TICKS);
      end else if (slow_tick) begin
        if (hold_r != 5'd0) hold_r <= hold_r - 5'd1;
        else if (tout_r != 16'h0000) tout_r <= tout_r - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // phase sequence check
  // ----------------------------------------------------------------
  zx_timing_pkg::seq_state_e seq_r, seq_nxt;
  logic seq_seen_r;
  logic seq_event;
  logic any_rise;

  assign any_rise = |volt_rise;
  assign seq_event = conn_three_sensors && any_rise && (seq_seen_r ||
    (seq_r == zx_timing_pkg::SEQ_AFTER_A && volt_rise[2] && !volt_rise[1]));
  assign seq_nxt = volt_rise[0] ? zx_timing_pkg::SEQ_AFTER_A :
                   volt_rise[1] ? zx_timing_pkg::SEQ_AFTER_B :
                   volt_rise[2] ? zx_timing_pkg::SEQ_AFTER_C : seq_r;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      seq_r <= zx_timing_pkg::SEQ_NONE;
      seq_seen_r <= 1'b0;
    end else if (!conn_three_sensors) begin
      seq_r <= zx_timing_pkg::SEQ_NONE;
      seq_seen_r <= 1'b0;
    end else begin
      seq_r <= seq_nxt;
      if (seq_event) seq_seen_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // status and interrupt
  // ----------------------------------------------------------------
  assign status_set = (32'(expire) << zx_timing_pkg::BIT_VOLT_TIMEOUT_LO)
                    | (32'(seq_event) << zx_timing_pkg::BIT_SEQUENCE_ERROR);
  assign status_clr = wr_status ? (pwdata & wmask & zx_timing_pkg::STATUS_FLAG_MASK)
                                : 32'h0000_0000;
  // a new event in the clearing cycle survives the clear
  assign status_nxt = (status_r & ~status_clr) | status_set;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) status_r <= 32'h0000_0000;
    else status_r <= status_nxt;
  end

  assign interrupt_line_one_n = ~|(status_r & mask_r);

  // ----------------------------------------------------------------
  // delay measurement
  // ----------------------------------------------------------------
  logic [2:0] pair_src;
  logic [2:0] start_ev, stop_ev;

  assign pair_src = (delay_sel == zx_timing_pkg::DELAY_CURR_CURR) ? curr_rise : volt_rise;
  // reserved selector code behaves like the default voltage-current set
  assign start_ev = (delay_sel == zx_timing_pkg::DELAY_VOLT_VOLT ||
                     delay_sel == zx_timing_pkg::DELAY_CURR_CURR) ?
                    {pair_src[0], pair_src[1], pair_src[0]} : volt_rise;
  assign stop_ev = (delay_sel == zx_timing_pkg::DELAY_VOLT_VOLT ||
                    delay_sel == zx_timing_pkg::DELAY_CURR_CURR) ?
                   {pair_src[1], pair_src[2], pair_src[2]} : curr_rise;

  for (genvar d = 0; d < 3; d++) begin : gen_delay
    logic [15:0] cnt_r;
    logic run_r;

    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        cnt_r <= 16'h0000;
        run_r <= 1'b0;
        delay_r[d] <= 16'h0000;
      end else if (stop_ev[d] && run_r) begin
        delay_r[d] <= cnt_r;
        run_r <= 1'b0;
      end else if (start_ev[d]) begin
        cnt_r <= 16'h0000;
        run_r <= 1'b1;
      end else if (run_r && fast_tick && cnt_r != 16'hffff) begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // line period measurement
  // ----------------------------------------------------------------
  // the first value after reset covers a partial period; the host lets it settle
  for (genvar p = 0; p < 3; p++) begin : gen_period
    logic [15:0] cnt_r;

    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        cnt_r <= 16'h0000;
        period_r[p] <= 16'h0000;
      end else if (volt_rise[p]) begin
        period_r[p] <= cnt_r;
        cnt_r <= 16'h0000;
      end else if (fast_tick && cnt_r != 16'hffff) begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_irq_low;
    @(posedge clock) disable iff (!rst_sync_n)
    (|(status_r & mask_r)) |-> !interrupt_line_one_n;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt not low");

  property p_flag_clear;
    @(posedge clock) disable iff (!rst_sync_n)
    (wr_status && pstrb[2] && pwdata[19] && !seq_event) |=> !status_r[19] ##0
    (interrupt_line_one_n || |(status_r & mask_r));
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_expire_sets;
    @(posedge clock) disable iff (!rst_sync_n)
    expire[3] |=> status_r[6] && (mask_r[6] -> !interrupt_line_one_n);
  endproperty
  a_expire_sets: assert property (p_expire_sets) else $error("timeout flag missing");

  property p_reload;
    @(posedge clock) disable iff (!rst_sync_n)
    cross_ok[3] |=> gen_tout[3].tout_r == $past(reload_r)
                    && gen_tout[3].hold_r == 5'd16;
  endproperty
  a_reload: assert property (p_reload) else $error("timeout not reloaded");

  property p_fast_spacing;
    @(posedge clock) disable iff (!rst_sync_n)
    fast_tick |=> !fast_tick [*8];
  endproperty
  a_fast_spacing: assert property (p_fast_spacing) else $error("fast tick too close");

  property p_seq_error;
    @(posedge clock) disable iff (!rst_sync_n)
    (conn_three_sensors && seq_r == zx_timing_pkg::SEQ_AFTER_A && volt_rise == 3'b100)
      |=> status_r[19] ##1 (seq_seen_r);
  endproperty
  a_seq_error: assert property (p_seq_error) else $error("sequence error missed");

  property p_seq_connection_select;
    @(posedge clock) disable iff (!rst_sync_n)
    !conn_three_sensors |-> !seq_event;
  endproperty
  a_seq_connection_select: assert property (p_seq_connection_select) else $error("sequence check active");

  property p_period;
    @(posedge clock) disable iff (!rst_sync_n)
    volt_rise[1] |=> period_r[1] == $past(gen_period[1].cnt_r) && gen_period[1].cnt_r == 16'h0;
  endproperty
  a_period: assert property (p_period) else $error("period not stored");

  property p_delay;
    @(posedge clock) disable iff (!rst_sync_n)
    (stop_ev[2] && gen_delay[2].run_r) |=> delay_r[2] == $past(gen_delay[2].cnt_r);
  endproperty
  a_delay: assert property (p_delay) else $error("delay not stored");

  property p_volt_pairs;
    @(posedge clock) disable iff (!rst_sync_n)
    (delay_sel == zx_timing_pkg::DELAY_VOLT_VOLT) |->
      start_ev == {volt_rise[0], volt_rise[1], volt_rise[0]} &&
      stop_ev == {volt_rise[1], volt_rise[2], volt_rise[2]};
  endproperty
  a_volt_pairs: assert property (p_volt_pairs) else $error("voltage pairs wrong");

  property p_curr_pairs;
    @(posedge clock) disable iff (!rst_sync_n)
    (delay_sel == zx_timing_pkg::DELAY_CURR_CURR) |->
      start_ev == {curr_rise[0], curr_rise[1], curr_rise[0]} &&
      stop_ev == {curr_rise[1], curr_rise[2], curr_rise[2]};
  endproperty
  a_curr_pairs: assert property (p_curr_pairs) else $error("current pairs wrong");

  property p_quiet;
    @(posedge clock) disable iff (!rst_sync_n)
    volt_below_noise[0] |-> !cross_ok[0];
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet crossing accepted");

endmodule

`default_nettype wire

// file: src/zx_timing_pkg.sv
// constants for the zero-crossing timing unit: register indices, field positions,
// reset values and timebase figures.
// assumes a 50 MHz system clock and a register index map reached at byte address = 4 * index.
`default_nettype none

package zx_timing_pkg;

  // ----------------------------------------------------------------
  // timebases
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_KHZ = 50000;
  localparam int unsigned FAST_TICK_KHZ = 256;
  localparam int unsigned SLOW_TICK_KHZ = 16;
  localparam int unsigned SLOW_DIV = FAST_TICK_KHZ / SLOW_TICK_KHZ;
  localparam int unsigned HOLD_TIME_US = 1000;
  // least time, so round up to whole slow ticks
  localparam int unsigned HOLD_TICKS = (HOLD_TIME_US * SLOW_TICK_KHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_MAIN_STATUS = 16'he503;
  localparam logic [15:0] IDX_MAIN_INTERRUPT_MASK = 16'he50b;
  localparam logic [15:0] IDX_DELAY_RESULT_0 = 16'he601;
  localparam logic [15:0] IDX_DELAY_RESULT_1 = 16'he602;
  localparam logic [15:0] IDX_DELAY_RESULT_2 = 16'he603;
  localparam logic [15:0] IDX_CROSSING_TIMEOUT_RELOAD = 16'he60d;
  localparam logic [15:0] IDX_COMPUTATION_MODE = 16'he60e;
  localparam logic [15:0] IDX_GENERAL_CONFIGURATION = 16'he618;
  localparam logic [15:0] IDX_ACCUMULATION_MODE = 16'he701;
  localparam logic [15:0] IDX_PHASE_A_LINE_PERIOD = 16'he905;
  localparam logic [15:0] IDX_PHASE_B_LINE_PERIOD = 16'he906;
  localparam logic [15:0] IDX_PHASE_C_LINE_PERIOD = 16'he907;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_VOLT_TIMEOUT_LO = 3;
  localparam int unsigned BIT_SEQUENCE_ERROR = 19;
  localparam int unsigned DELAY_SET_SELECT_LO = 9;
  localparam int unsigned CONNECTION_SELECT_LO = 4;
  localparam int unsigned VOLTAGE_ROUTE_A_LO = 8;
  localparam int unsigned VOLTAGE_ROUTE_B_LO = 10;
  localparam int unsigned VOLTAGE_ROUTE_C_LO = 12;

  // ----------------------------------------------------------------
  // reset values and implemented bits
  // ----------------------------------------------------------------
  localparam logic [15:0] RELOAD_RESET = 16'hffff;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [7:0] ACCUM_RESET = 8'h00;
  localparam logic [31:0] STATUS_FLAG_MASK = 32'h0008_01f8;

  typedef enum logic [1:0] {
    DELAY_VOLT_CURR,
    DELAY_VOLT_VOLT,
    DELAY_CURR_CURR,
    DELAY_RESERVED
  } delay_set_e;

  typedef enum logic [1:0] {
    SEQ_NONE,
    SEQ_AFTER_A,
    SEQ_AFTER_B,
    SEQ_AFTER_C
  } seq_state_e;

endpackage

`default_nettype wire
